// File: cscrc_host_end.sv
// Host end: makes the socket clock, manages slow and stop, drives socket reset.
`timescale 1ns/1ps
`default_nettype none
module cscrc_host_end
    import cscrc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    cscrc_if.host                  sock,
    input  wire logic [1:0]        power_mode,
    input  wire logic              reset_req,
    output logic [DATA_W-1:0]      sampled_data,
    output logic [3:0]             clock_state,
    output logic                   card_run_req,
    output logic                   reset_active
);
    cscrc_state_t      state_q;
    cscrc_state_t      state_d;
    logic [HALF_W-1:0] div_q;
    logic [HALF_W-1:0] ann_q;
    logic              sclk_q;
    logic              rst_n_q;
    logic              run_oe_q;
    logic              park_oe_q;
    logic              run_s1_q;
    logic              run_s2_q;
    logic [DATA_W-1:0] data_s1_q;
    logic [DATA_W-1:0] data_s2_q;
    logic [DATA_W-1:0] sampled_q;
    logic              card_req_q;
    logic              hold;
    logic              tick;
    logic              rise;
    logic              fall;
    logic              card_req;
    logic              want_full;

    // Half period of the socket clock in host clock cycles.
    function automatic logic [HALF_W-1:0] half_len(input cscrc_state_t st);
        begin
            half_len = (st == ST_SLOW) ? SLOW_HALF : FULL_HALF;
        end
    endfunction

    // Clock-run and socket data are pins, so both pass two flip-flops.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_s1_q  <= 1'b1;
            run_s2_q  <= 1'b1;
            data_s1_q <= DATA_ZERO;
            data_s2_q <= DATA_ZERO;
        end
        else
        begin
            run_s1_q  <= sock.socket_clock_run_line_n;
            run_s2_q  <= run_s1_q;
            data_s1_q <= sock.socket_data;
            data_s2_q <= data_s1_q;
        end
    end

    // The line is low only by the card while the host has let it go. [R4]
    assign card_req  = ~run_s2_q & ~run_oe_q &
                       ((state_q != ST_ANNOUNCE) || (ann_q >= ANN_WATCH));
    // Reset forces the full clock so the release sees live edges. [R11]
    assign want_full = (power_mode == MODE_FULL) || card_req || !rst_n_q || reset_req;

    // A stopped clock freezes only once it is low. [R3]
    assign hold = (state_q == ST_STOP) && !sclk_q;
    // A count left over from the slow half period ends at once on a return to full rate.
    assign tick = !hold && (div_q >= half_len(state_q) - HALF_ONE);
    assign rise = tick & ~sclk_q;
    assign fall = tick & sclk_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
            begin
                if (!want_full)
                begin
                    state_d = ST_ANNOUNCE;
                end
            end
            ST_ANNOUNCE:
            begin
                if (want_full)
                begin
                    state_d = ST_RUN;
                end
                else if (ann_q == ANN_LAST)
                begin
                    state_d = (power_mode == MODE_SLOW) ? ST_SLOW : ST_STOP;
                end
            end
            ST_SLOW:
            begin
                if (want_full)
                begin
                    state_d = ST_RUN;
                end
                else if (power_mode == MODE_STOP)
                begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP:
            begin
                if (want_full)
                begin
                    state_d = ST_RUN;
                end
                else if (power_mode == MODE_SLOW)
                begin
                    state_d = ST_SLOW;
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_RUN;
            ann_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            // The announcement lasts a fixed count before any slowdown. [R5]
            if (state_q == ST_ANNOUNCE)
            begin
                ann_q <= ann_q + HALF_ONE;
            end
            else
            begin
                ann_q <= '0;
            end
        end
    end

    // The host holds clock-run low while running and lets go to announce. [R5]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_oe_q <= 1'b1;
        end
        else
        begin
            run_oe_q <= (state_d == ST_RUN);
        end
    end

    // Socket clock divider: full rate in run, slower in slow, parked low in stop.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_q  <= '0;
            sclk_q <= 1'b0;
        end
        else if (hold)
        begin
            div_q <= '0;
        end
        else if (tick)
        begin
            div_q  <= '0;
            sclk_q <= ~sclk_q; // [R2] [R3]
        end
        else
        begin
            div_q <= div_q + HALF_ONE;
        end
    end

    // Assert at once on request; release only with a falling clock edge. [R9] [R10] [R11]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_n_q <= 1'b0;
        end
        else if (reset_req)
        begin
            rst_n_q <= 1'b0;
        end
        else if (!rst_n_q && fall && state_q == ST_RUN)
        begin
            rst_n_q <= 1'b1;
        end
    end

    // Park the floated socket lines at a valid level during reset. [R8]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            park_oe_q <= 1'b1;
        end
        else
        begin
            park_oe_q <= reset_req | ~rst_n_q;
        end
    end

    // Card data is taken at the host's own socket clock rise. [R1]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sampled_q  <= DATA_ZERO;
            card_req_q <= 1'b0;
        end
        else
        begin
            card_req_q <= card_req;
            if (rise && rst_n_q)
            begin
                sampled_q <= data_s2_q;
            end
        end
    end

    assign sock.socket_clock   = sclk_q;
    assign sock.socket_reset_n = rst_n_q;
    assign sock.host_run_oe    = run_oe_q;
    assign sock.host_park_o    = PARK_LEVEL;
    assign sock.host_park_oe   = park_oe_q;
    assign sampled_data        = sampled_q;
    assign clock_state         = state_q;
    assign card_run_req        = card_req_q;
    assign reset_active        = park_oe_q;
endmodule // cscrc_host_end
`default_nettype wire

// File: cscrc_pkg.sv
// Shared constants and types for the socket clock and reset control ends.
// What this block does
// R1: Socket signals sampled on clock rise; listed ones asynchronous.
// R2: Normal socket clock runs at half the host clock rate.
// R3: Clock may stop, only held low, or slow.
// R4: Card pulls clock-run to ask faster clock.
// R5: Host announces clock drop on clock-run first.
// R6: Card reset returns card state to initial.
// R7: Card floats all socket outputs during reset.
// R8: Host parks floated signals at valid levels.
// R9: Host may assert reset at any moment.
// R10: Host releases reset aligned to clock edge.
// R11: Reset release from flop, clock kept running.
`default_nettype none
package cscrc_pkg;
    localparam int          DATA_W        = 8;
    localparam int          HALF_W        = 4;
    localparam int          CNT_W         = 8;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          ANNOUNCE_NS   = 160;
    // Least time, so the cycle count rounds up.
    localparam int          ANNOUNCE_CYC  = (ANNOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SYNC_DEPTH    = 2;
    localparam logic [HALF_W-1:0] FULL_HALF = 4'h1;
    localparam logic [HALF_W-1:0] SLOW_HALF = 4'h8;
    localparam logic [HALF_W-1:0] HALF_ONE  = 4'h1;
    localparam logic [HALF_W-1:0] ANN_LAST  = HALF_W'(ANNOUNCE_CYC - 1);
    localparam logic [HALF_W-1:0] ANN_WATCH = HALF_W'(SYNC_DEPTH);
    localparam logic [DATA_W-1:0] PARK_LEVEL = 8'hFF;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 8'h01;

    typedef enum logic [1:0]
    {
        MODE_FULL = 2'h0,
        MODE_SLOW = 2'h1,
        MODE_STOP = 2'h2
    } cscrc_mode_t;

    typedef enum logic [3:0]
    {
        ST_RUN      = 4'h1,
        ST_ANNOUNCE = 4'h2,
        ST_SLOW     = 4'h4,
        ST_STOP     = 4'h8
    } cscrc_state_t;
endpackage
`default_nettype wire

// File: cscrc_if.sv
// Socket pins between the host end and the card end, with wire resolution.
`timescale 1ns/1ps
`default_nettype none
interface cscrc_if;
    import cscrc_pkg::*;
    logic              socket_clock;
    logic              socket_reset_n;
    logic              host_run_oe;
    logic              card_run_oe;
    logic              socket_clock_run_line_n;
    logic [DATA_W-1:0] card_data_o;
    logic              card_data_oe;
    logic [DATA_W-1:0] host_park_o;
    logic              host_park_oe;
    logic [DATA_W-1:0] socket_data;

    // The clock-run line is open drain with a pull-up; either end pulls it low.
    assign socket_clock_run_line_n = ~(host_run_oe | card_run_oe);
    // The card wins when it drives; the host park level fills in; else pull-up.
    assign socket_data = card_data_oe ? card_data_o
                       : (host_park_oe ? host_park_o : PARK_LEVEL);

    modport host
    (
        output socket_clock,
        output socket_reset_n,
        output host_run_oe,
        output host_park_o,
        output host_park_oe,
        input  socket_clock_run_line_n,
        input  socket_data
    );

    modport card
    (
        input  socket_clock,
        input  socket_reset_n,
        input  socket_clock_run_line_n,
        input  socket_data,
        output card_run_oe,
        output card_data_o,
        output card_data_oe
    );
endinterface // cscrc_if
`default_nettype wire

// File: cscrc_card_end.sv
// Card end: follows socket clock and reset, requests faster clock, drives data.
`timescale 1ns/1ps
`default_nettype none
module cscrc_card_end
    import cscrc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    cscrc_if.card                  sock,
    input  wire logic              need_fast,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_enable,
    output logic [CNT_W-1:0]       edge_count,
    output logic                   in_reset
);
    logic              clk_s1_q;
    logic              clk_s2_q;
    logic              clk_prev_q;
    logic              rst_s1_q;
    logic              rst_s2_q;
    logic              run_oe_q;
    logic [DATA_W-1:0] data_q;
    logic              data_oe_q;
    logic [CNT_W-1:0]  edge_count_q;
    logic              in_reset_q;
    logic              rise;
    logic              resetting;

    // Socket clock and reset are pins, so both pass two flip-flops.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clk_s1_q   <= 1'b0;
            clk_s2_q   <= 1'b0;
            clk_prev_q <= 1'b0;
            rst_s1_q   <= 1'b0;
            rst_s2_q   <= 1'b0;
        end
        else
        begin
            clk_s1_q   <= sock.socket_clock;
            clk_s2_q   <= clk_s1_q;
            clk_prev_q <= clk_s2_q;
            rst_s1_q   <= sock.socket_reset_n;
            rst_s2_q   <= rst_s1_q;
        end
    end

    assign rise      = clk_s2_q & ~clk_prev_q;
    assign resetting = ~rst_s2_q;

    // Reset clears the card sequencer and floats every output. [R6] [R7]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_q       <= DATA_ZERO;
            data_oe_q    <= 1'b0;
            edge_count_q <= '0;
        end
        else if (resetting)
        begin
            data_q       <= DATA_ZERO;
            data_oe_q    <= 1'b0;
            edge_count_q <= '0;
        end
        else if (rise)
        begin
            // Data changes only at socket clock rises. [R1]
            data_q       <= tx_data;
            data_oe_q    <= tx_enable;
            edge_count_q <= edge_count_q + CNT_ONE;
        end
    end

    // The card holds clock-run low while it needs the full clock. [R4] [R7]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_oe_q   <= 1'b0;
            in_reset_q <= 1'b1;
        end
        else
        begin
            run_oe_q   <= need_fast & ~resetting;
            in_reset_q <= resetting;
        end
    end

    assign sock.card_run_oe  = run_oe_q;
    assign sock.card_data_o  = data_q;
    assign sock.card_data_oe = data_oe_q;
    assign edge_count        = edge_count_q;
    assign in_reset          = in_reset_q;
endmodule // cscrc_card_end
`default_nettype wire

// File: cscrc_props.sv
// Concurrent checks on the socket pins between the host end and the card end.
`timescale 1ns/1ps
`default_nettype none
module cscrc_props
    import cscrc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic socket_clock,
    input  wire logic socket_reset_n,
    input  wire logic host_run_oe,
    input  wire logic card_run_oe,
    input  wire logic card_data_oe,
    input  wire logic host_park_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_full_rate_run: assert property (host_run_oe [*3] |-> $changed(socket_clock))
        else $error("socket clock not at full rate");
    a_slow_high_max: assert property (socket_clock [*8] |=> !socket_clock)
        else $error("socket clock held high");
    a_announce_first: assert property ($fell(host_run_oe) |-> $changed(socket_clock) [*4])
        else $error("clock dropped during announce");
    a_card_floats: assert property (!socket_reset_n [*4] |-> !card_data_oe && !card_run_oe)
        else $error("card drives during socket reset");
    a_park_in_reset: assert property (!socket_reset_n |-> host_park_oe)
        else $error("host not parking during socket reset");
    a_park_release: assert property ($rose(socket_reset_n) |=> !host_park_oe)
        else $error("park not dropped after release");
    a_release_on_fall: assert property ($rose(socket_reset_n) |-> $fell(socket_clock))
        else $error("reset release not on clock fall");
    a_clock_through_release: assert property ($rose(socket_reset_n) |=> socket_clock ##1 !socket_clock)
        else $error("clock not running through release");

    c_release: cover property ($rose(socket_reset_n));
    c_announce: cover property ($fell(host_run_oe));
    c_stopped: cover property (!socket_clock [*8]);
    c_card_request: cover property (card_run_oe && !host_run_oe);
endmodule // cscrc_props
`default_nettype wire

// File: tb.sv
// Self-checking bench joining the host end and the card end.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cscrc_pkg::*;
    logic              clk;
    logic              rstn;
    logic [1:0]        power_mode;
    logic              reset_req;
    logic              need_fast;
    logic [DATA_W-1:0] tx_data;
    logic              tx_enable;
    logic [DATA_W-1:0] sampled_data;
    logic [3:0]        clock_state;
    logic              card_run_req;
    logic              reset_active;
    logic [CNT_W-1:0]  edge_count;
    logic              in_reset;
    logic [CNT_W-1:0]  cnt0;
    int                num_errors;
    int                n_compared;
    int                i;
    int                k;

    cscrc_if sock();
    cscrc_host_end cscrc_host_end_inst (.clk(clk), .rstn(rstn), .sock(sock.host),
        .power_mode(power_mode), .reset_req(reset_req), .sampled_data(sampled_data),
        .clock_state(clock_state), .card_run_req(card_run_req), .reset_active(reset_active));
    cscrc_card_end cscrc_card_end_inst (.clk(clk), .rstn(rstn), .sock(sock.card),
        .need_fast(need_fast), .tx_data(tx_data), .tx_enable(tx_enable),
        .edge_count(edge_count), .in_reset(in_reset));
    cscrc_props cscrc_props_inst (.clk(clk), .rstn(rstn), .socket_clock(sock.socket_clock),
        .socket_reset_n(sock.socket_reset_n), .host_run_oe(sock.host_run_oe),
        .card_run_oe(sock.card_run_oe), .card_data_oe(sock.card_data_oe),
        .host_park_oe(sock.host_park_oe));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [3:0] exp_state(input logic [1:0] mode);
        return (mode == 2'h0) ? ST_RUN : ((mode == 2'h1) ? ST_SLOW : ST_STOP);
    endfunction

    // A floated card leaves the socket data at the pull-up level.
    function automatic logic [7:0] exp_data(input logic [7:0] d, input logic en);
        return en ? d : PARK_LEVEL;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_state(input logic [3:0] got, input logic [3:0] exp, input string what);
        chk_val({4'h0, got}, {4'h0, exp}, what);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val({7'h00, got}, {7'h00, exp}, what);
    endtask

    // Counts socket clock rises over 64 cycles, a whole number of periods in both full and slow mode.
    task automatic rate(input int exp);
        cnt0 = edge_count;
        step(64);
        chk_val(8'(edge_count - cnt0), 8'(exp), "clock rises");
    endtask

    task automatic wait_in_reset(input logic val);
        for (k = 0; k < 60 && in_reset !== val; k++)
            step(1);
        chk_bit(in_reset, val, "card reset view");
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 4000);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        end_sim;
    end

    initial
    begin
        rstn = 1'b0;
        power_mode = 2'h0;
        reset_req = 1'b0;
        need_fast = 1'b0;
        tx_data = 8'h00;
        tx_enable = 1'b1;
        num_errors = 0;
        n_compared = 0;
        k = $urandom(32'h4E227128);
        step(3);
        rstn = 1'b1;
        wait_in_reset(1'b0);
        chk_state(clock_state, ST_RUN, "state after reset");
        chk_bit(reset_active, 1'b0, "reset active");
        $display("test reset done");
        for (i = 0; i < 4; i++)
        begin
            tx_data = (i == 0) ? 8'h00 : 8'($urandom);
            tx_enable = (i != 2);
            step(12);
            chk_val(sampled_data, exp_data(tx_data, tx_enable), "sampled data");
        end
        rate(32);
        $display("test data done");
        power_mode = 2'h2;
        step(1);
        chk_state(clock_state, ST_ANNOUNCE, "announce");
        chk_bit(sock.host_run_oe, 1'b0, "line released");
        step(3);
        chk_state(clock_state, ST_ANNOUNCE, "announce held");
        step(1);
        chk_state(clock_state, ST_STOP, "stop");
        for (i = 0; i < 8; i++)
        begin
            power_mode = (i < 4) ? 2'(8'hC9 >> (2 * i)) : 2'($urandom_range(0, 3));
            step(12);
            chk_state(clock_state, exp_state(power_mode), "mode state");
            if (power_mode == 2'h1)
                rate(4);
            else if (power_mode == 2'h0)
                rate(32);
            else
                chk_bit(sock.socket_clock, 1'b0, "stopped low");
        end
        power_mode = 2'h0;
        step(4);
        $display("test power modes done");
        need_fast = 1'b1;
        step(6);
        power_mode = 2'h1;
        step(12);
        chk_state(clock_state, ST_RUN, "slowdown refused");
        chk_bit(card_run_req, 1'b1, "card request seen");
        need_fast = 1'b0;
        step(16);
        chk_state(clock_state, ST_SLOW, "slow after release");
        need_fast = 1'b1;
        step(8);
        chk_state(clock_state, ST_RUN, "raised on request");
        need_fast = 1'b0;
        power_mode = 2'h0;
        step(4);
        $display("test card request done");
        power_mode = 2'h2;
        step(2 + $urandom_range(0, 7));
        chk_bit(sock.card_data_oe, 1'b1, "card driving");
        reset_req = 1'b1;
        step(1);
        chk_bit(sock.socket_reset_n, 1'b0, "reset asserted");
        chk_bit(sock.host_park_oe, 1'b1, "park on");
        step(4);
        chk_bit(in_reset, 1'b1, "card in reset");
        chk_val(edge_count, 8'h00, "card count cleared");
        chk_bit(sock.card_data_oe, 1'b0, "card floated");
        chk_state(clock_state, ST_RUN, "run in reset");
        power_mode = 2'h0;
        reset_req = 1'b0;
        wait_in_reset(1'b0);
        chk_bit(sock.host_park_oe, 1'b0, "park off");
        rate(32);
        $display("test socket reset done");
        end_sim;
    end
endmodule // tb
`default_nettype wire
